// [logic/ssp_core.sv]
// Purpose: serial port control, data window, fifos and shift engine
// Assumes: link pins come from outside the clock domain, sampled here
// Notes:   bit rate is core_clk / (2 * (1 + clk_rate)), prescale fixed at 2
//
// Overview of operation
// R1 - wire-count bit: clear is four-wire (reset), set is three-wire.
// R2 - three-wire only: command/data line present bit, clear by default.
// R3 - three-wire command/data kind: 0 command (reset), 1 data.
// R4 - three-wire direction: 0 read, 1 write; register resets to 0x80.
// R5 - receive bit order: 0 msb first, 1 lsb first, word length honoured.
// R6 - transmit bit order: 0 msb first, 1 lsb first, word length honoured.
// R7 - microwire: slave receives 8-bit items, master uses configured length.
// R8 - microwire: master transmits 8-bit items, slave uses configured length.
// R9 - three-wire keeps both bit orders at msb first unless slave allows; the logic honours both order bits as written in every mode.
// R10 - slave with output disable set leaves serial output undriven.
// R11 - role bit: 0 master, 1 slave; writable only while port disabled.
// R12 - three-wire mode works as master only.
// R13 - port enable gates all transfers.
// R14 - echo bit feeds transmit shifter output into receive shifter.
// R15 - data window write pushes transmit fifo, read pops receive fifo.
// R16 - short words are right-justified both ways, upper bits ignored.
// R17 - size code plus one gives 4..16 bits; codes 0..2 reserved.
// R18 - three-wire with line present drives command/data kind during transfer.
`timescale 1ns/100ps

// ==========================================================
// synchronous fifo
module ssp_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             do_wr;
  logic             do_rd;

  // honest flags straight from the fill count
  // one counter feeds both flags, so full and empty can never disagree
  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  assign do_wr     = in_valid & in_ready;
  assign do_rd     = out_valid & out_ready;

  // storage, no reset needed on the array
  // a write to a full fifo is refused here, the caller sees in_ready low
  always_ff @(posedge core_clk) begin
    if (do_wr) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // pointers wrap at depth
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (do_rd) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end
endmodule

// ==========================================================
// top: register port, fifos and shift engine
module ssp_core import ssp_pkg::*; #(
  parameter int DATA_W = SSP_DATA_W,
  parameter int DEPTH  = SSP_FIFO_DEPTH
) (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  // serial clock and select
  input  wire logic        sclk_in,
  output logic             sclk_o,
  output logic             sclk_oe_n,
  input  wire logic        sel_n_in,
  output logic             sel_n_o,
  // data lines
  input  wire logic        rxd_in,
  output logic             serial_output_line,
  output logic             txd_oe_n,
  // command/data line
  output logic             cmd_data_o,
  output logic             cmd_data_oe_n
);
  ssp_ctrl_first_t     ctl1;
  ssp_ctrl_second_t    ctl2;
  ssp_state_t          state;
  logic [2:0]          sync1;
  logic [2:0]          sync2;
  logic                sclk_prev;
  logic [8:0]          div_cnt;
  logic                tick;
  logic [4:0]          cnt;
  logic [DATA_W-1:0]   tx_word;
  logic [DATA_W-1:0]   acc;
  logic                slave_eff;
  logic                sel_act;
  logic                samp_ev;
  logic                shift_ev;
  logic                rx_bit;
  logic [4:0]          size_w;
  logic [4:0]          tx_w;
  logic [4:0]          rx_w;
  logic [4:0]          frame_len;
  logic                mw;
  logic                load_ev;
  logic                last_shift;
  logic                tx_valid;
  logic [DATA_W-1:0]   tx_data;
  logic                tx_ready;
  logic                rx_valid;
  logic [DATA_W-1:0]   rx_data;
  logic                rx_ready;
  logic                rx_pop;
  logic                wr_data;
  logic                rd_data;

  // ==========================================================
  // pin synchronisers: only the second stage is read
  // reset to the idle pin levels so no false edge follows reset
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1     <= 3'b010;
      sync2     <= 3'b010;
      sclk_prev <= 1'b0;
    end else begin
      sync1     <= {sclk_in, sel_n_in, rxd_in};
      sync2     <= sync1;
      sclk_prev <= sync2[2];
    end
  end

  // ==========================================================
  // word widths and role
  // reserved size codes fall back to the smallest legal width
  // frame length covers the longer of the two directions
  assign mw        = (ctl1.frame_fmt == SSP_FMT_MICROWIRE);
  assign slave_eff = ctl2.role_bit & ~ctl2.three_wire;        // [R12]
  assign size_w    = (ctl1.data_size < SSP_SIZE_MIN_CODE) ? SSP_MIN_WIDTH
                   : {1'b0, ctl1.data_size} + 5'd1;            // [R17]
  assign tx_w      = (mw & ~slave_eff) ? SSP_MW_WIDTH : size_w; // [R8]
  assign rx_w      = (mw & slave_eff) ? SSP_MW_WIDTH : size_w;  // [R7]
  assign frame_len = (tx_w > rx_w) ? tx_w : rx_w;

  // bit of a word at a given shift position, zero past its width
  // bit order is honoured as written in every mode; three-wire users keep
  // both orders at msb first unless the far device takes the other
  function automatic logic tx_bit(input logic [DATA_W-1:0] w,
                                  input logic [4:0] pos,
                                  input logic [4:0] wid,
                                  input logic lsb);
    logic [4:0] idx;
    idx = lsb ? pos : wid - 5'd1 - pos;                         // [R6] [R9]
    tx_bit = (pos < wid) ? w[idx[3:0]] : 1'b0;                  // [R16]
  endfunction

  // ==========================================================
  // register port: writes, width-checked decode
  // reserved bit 6 is never stored, so it always reads back as zero
  assign wr_data = reg_wr & (reg_addr == SSP_OFF_DATA);
  assign rd_data = reg_rd & (reg_addr == SSP_OFF_DATA);
  assign rx_pop  = rd_data;                                     // [R15]

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl1 <= SSP_RST_CTRL_FIRST;
      ctl2 <= SSP_RST_CTRL_SECOND;                              // [R1] [R2] [R3] [R4]
    end else if (reg_wr) begin
      if (reg_addr == SSP_OFF_CTRL_FIRST) begin
        ctl1 <= reg_wdata[15:0];
      end
      if (reg_addr == SSP_OFF_CTRL_SECOND) begin
        ctl2       <= reg_wdata[10:0];
        ctl2.rsvd6 <= 1'b0;
        // role change refused while running
        if (ctl2.port_enable_bit) begin
          ctl2.role_bit <= ctl2.role_bit;                       // [R11]
        end
      end
    end
  end

  // read data stands one cycle after the strobe
  // status: busy, rx full, rx not empty, tx not full, tx empty
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        SSP_OFF_CTRL_FIRST:  reg_rdata <= {16'h0000, ctl1};
        SSP_OFF_CTRL_SECOND: reg_rdata <= {21'h0, ctl2};
        SSP_OFF_DATA:        reg_rdata <= rx_valid ? 32'(rx_data) : '0; // [R16]
        SSP_OFF_STATUS:      reg_rdata <= {27'h0, (state != SSP_ST_IDLE) | tx_valid,
                                           ~rx_ready, rx_valid, tx_ready, ~tx_valid};
        default:             reg_rdata <= '0;
      endcase
    end
  end

  // ==========================================================
  // fifos; a full transmit fifo drops the write, see status
  // the receive fifo has no overrun flag; a master waits for room instead
  ssp_fifo #(.WIDTH(DATA_W), .DEPTH(DEPTH)) u_tx_fifo (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .in_valid  (wr_data),                                        // [R15]
    .in_ready  (tx_ready),
    .in_data   (reg_wdata[DATA_W-1:0]),
    .out_valid (tx_valid),
    .out_ready (load_ev),
    .out_data  (tx_data)
  );

  ssp_fifo #(.WIDTH(DATA_W), .DEPTH(DEPTH)) u_rx_fifo (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .in_valid  (last_shift),
    .in_ready  (rx_ready),
    .in_data   (acc),
    .out_valid (rx_valid),
    .out_ready (rx_pop),
    .out_data  (rx_data)
  );

  // ==========================================================
  // master bit-rate divider, one-cycle tick per half period
  // parked in slave role, so a later switch to master starts a clean phase
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= '0;
    end else if (tick | slave_eff) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + 9'd1;
    end
  end
  assign tick = ~slave_eff & (div_cnt == {1'b0, ctl1.clk_rate});

  // ==========================================================
  // engine events
  // echo takes the registered output, so internal_echo sees what the pin shows
  assign sel_act  = ~sync2[1];
  assign rx_bit   = ctl2.internal_echo ? serial_output_line : sync2[0]; // [R14]
  assign samp_ev  = (state == SSP_ST_RUN) &
                    (slave_eff ? (sync2[2] & ~sclk_prev) : (tick & ~sclk_o));
  assign shift_ev = (state == SSP_ST_RUN) &
                    (slave_eff ? (~sync2[2] & sclk_prev) : (tick & sclk_o));
  assign last_shift = shift_ev & (cnt == frame_len - 5'd1);
  // master waits for receive room so its frames never overrun the rx fifo; slave frames can
  assign load_ev  = ctl2.port_enable_bit & (state == SSP_ST_IDLE) & tx_valid &
                    (slave_eff ? sel_act : (tick & rx_ready));   // [R13]

  // ==========================================================
  // shift engine
  // sampling on one serial clock edge and shifting on the other never collide
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state              <= SSP_ST_IDLE;
      cnt                <= '0;
      tx_word            <= '0;
      acc                <= '0;
      sclk_o             <= 1'b0;
      sel_n_o            <= 1'b1;
      serial_output_line <= 1'b0;
    end else if (!ctl2.port_enable_bit) begin
      // disabling aborts any frame in flight
      state   <= SSP_ST_IDLE;                                    // [R13]
      sclk_o  <= 1'b0;
      sel_n_o <= 1'b1;
    end else begin
      case (state)
        SSP_ST_IDLE: begin
          // slave with an empty fifo still answers, sending zeros
          if (load_ev | (slave_eff & sel_act)) begin
            tx_word            <= tx_valid ? tx_data : '0;
            cnt                <= '0;
            acc                <= '0;
            serial_output_line <= tx_bit(tx_valid ? tx_data : '0, 5'd0,
                                         tx_w, ctl2.tx_lsb);
            sel_n_o            <= slave_eff;
            state              <= SSP_ST_RUN;
          end
        end
        SSP_ST_RUN: begin
          if (tick) begin
            sclk_o <= ~sclk_o;
          end
          if (slave_eff & ~sel_act) begin
            state <= SSP_ST_IDLE;
          end else if (samp_ev) begin
            if (cnt < rx_w) begin
              if (ctl2.rx_lsb) begin
                acc[cnt[3:0]] <= rx_bit;                         // [R5] [R9]
              end else begin
                acc <= {acc[DATA_W-2:0], rx_bit};                // [R16]
              end
            end
          end else if (shift_ev) begin
            if (last_shift) begin
              state <= slave_eff ? SSP_ST_IDLE : SSP_ST_DONE;
            end else begin
              cnt                <= cnt + 5'd1;
              serial_output_line <= tx_bit(tx_word, cnt + 5'd1, tx_w, ctl2.tx_lsb);
            end
          end
        end
        SSP_ST_DONE: begin
          // one more half period of select for the far side's hold time
          if (tick) begin
            sel_n_o <= 1'b1;
            state   <= SSP_ST_IDLE;
          end
        end
        default: state <= SSP_ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // pin enables; three-wire read releases the shared data line
  // enables lag the control word by one cycle but stay flop-driven
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_oe_n     <= 1'b1;
      txd_oe_n      <= 1'b1;
      cmd_data_o    <= 1'b0;
      cmd_data_oe_n <= 1'b1;
    end else begin
      sclk_oe_n <= slave_eff | ~ctl2.port_enable_bit;
      if (slave_eff) begin
        txd_oe_n <= ~sel_act | ctl2.slave_output_disable;        // [R10]
      end else begin
        txd_oe_n <= ~ctl2.port_enable_bit
                  | (ctl2.three_wire & ~ctl2.dir_write);         // [R4] [R1]
      end
      cmd_data_o    <= ctl2.cmd_data_kind;                       // [R3]
      cmd_data_oe_n <= ~(ctl2.three_wire & ctl2.cmd_data_line_present
                         & (state != SSP_ST_IDLE));              // [R18] [R2]
    end
  end
endmodule

// [logic/ssp_pkg.sv]
// Purpose: shared constants and types of the serial port block
// Assumes: byte addressed register port, 32-bit data
// Notes:   offsets are byte addresses, one aligned word per register
package ssp_pkg;
  // ==========================================================
  // register map
  localparam logic [7:0] SSP_OFF_CTRL_FIRST  = 8'h00;
  localparam logic [7:0] SSP_OFF_CTRL_SECOND = 8'h04;
  localparam logic [7:0] SSP_OFF_DATA        = 8'h08;
  localparam logic [7:0] SSP_OFF_STATUS      = 8'h0C;
  // ==========================================================
  // reset values and sizes
  localparam logic [15:0] SSP_RST_CTRL_FIRST  = 16'h0000;
  localparam logic [10:0] SSP_RST_CTRL_SECOND = 11'h080;
  localparam int          SSP_DATA_W          = 16;
  localparam int          SSP_FIFO_DEPTH      = 8;
  localparam logic [4:0]  SSP_MW_WIDTH        = 5'd8;   // fixed microwire item width
  localparam logic [4:0]  SSP_MIN_WIDTH       = 5'd4;   // used for reserved size codes
  localparam logic [3:0]  SSP_SIZE_MIN_CODE   = 4'h3;
  localparam logic [1:0]  SSP_FMT_MICROWIRE   = 2'b10;
  // ==========================================================
  // control words
  typedef struct packed {
    logic [7:0] clk_rate;
    logic       clk_phase;
    logic       clk_polarity;
    logic [1:0] frame_fmt;
    logic [3:0] data_size;
  } ssp_ctrl_first_t;

  typedef struct packed {
    logic three_wire;
    logic cmd_data_line_present;
    logic cmd_data_kind;
    logic dir_write;
    logic rsvd6;
    logic rx_lsb;
    logic tx_lsb;
    logic slave_output_disable;
    logic role_bit;
    logic port_enable_bit;
    logic internal_echo;
  } ssp_ctrl_second_t;

  typedef enum logic [2:0] {
    SSP_ST_IDLE = 3'b001,
    SSP_ST_RUN  = 3'b010,
    SSP_ST_DONE = 3'b100
  } ssp_state_t;
endpackage

// [dv/ssp_link_slave.sv]
// Purpose: serial slave model facing the port in master role
// Assumes: mode 0 timing, data changes on falling serial clock
// Notes:   released data line shows the inverse of its last value
`timescale 1ns/100ps
// ==========================================================
// slave model
module ssp_link_slave (
  // link from the port
  input  wire logic        sclk,
  input  wire logic        sel_n,
  input  wire logic        mosi,
  output logic             miso,
  // scenario control
  input  wire logic [15:0] reply,
  output logic [15:0]      seen
);
  logic [15:0] sr = 16'h0000;
  initial miso = 1'b0;
  initial seen = 16'h0000;
  // load reply on select, msb first only
  always @(negedge sel_n) begin
    sr   = reply;
    seen = 16'h0000;
    miso = reply[15];
  end
  // capture on rise, next bit on fall
  always @(posedge sclk) begin
    if (!sel_n) seen = {seen[14:0], mosi};
  end
  always @(negedge sclk) begin
    if (!sel_n) begin
      sr   = sr << 1;
      miso = sr[15];
    end
  end
  // no pull on this line, so never leave the old bit standing
  always @(posedge sel_n) miso = ~miso;
endmodule

// [dv/ssp_core_chk.sv]
// Purpose: concurrent checks on the serial port top
// Assumes: control shadow follows register writes
// Notes:   st gives registered outputs one cycle after a control write
`timescale 1ns/100ps
// ==========================================================
// checker
module ssp_core_chk import ssp_pkg::*; (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [31:0] reg_rdata,
  // link pins
  input  wire logic        sclk_o,
  input  wire logic        sclk_oe_n,
  input  wire logic        sel_n_o,
  input  wire logic        txd_oe_n,
  input  wire logic        cmd_data_o,
  input  wire logic        cmd_data_oe_n
);
  ssp_ctrl_second_t sh;
  logic             st;
  // shadow control word, role frozen while enabled
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sh <= ssp_ctrl_second_t'(SSP_RST_CTRL_SECOND);
    end else if (reg_wr && reg_addr == SSP_OFF_CTRL_SECOND) begin
      sh <= ssp_ctrl_second_t'(reg_wdata[10:0]);
      if (sh.port_enable_bit) sh.role_bit <= sh.role_bit;
    end
  end
  // settled flag
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) st <= 1'b0;
    else st <= !(reg_wr && reg_addr == SSP_OFF_CTRL_SECOND);
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_ctrl_readback: assert property (
    reg_rd && reg_addr == SSP_OFF_CTRL_SECOND |=> reg_rdata == {21'h0, sh & 11'h7BF})
    else $error("control readback differs");
  a_unmapped_zero: assert property (reg_rd && reg_addr == 8'h30 |=> reg_rdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_disabled_idle: assert property (
    !sh.port_enable_bit && st |-> sel_n_o && !sclk_o) else $error("link active while off");
  a_sclk_rest: assert property (
    sel_n_o |-> !sclk_o) else $error("serial clock moves outside frame");
  a_master_drive: assert property (
    sh.port_enable_bit && (!sh.role_bit || sh.three_wire) && st |-> !sclk_oe_n)
    else $error("master not driving clock");
  a_slave_quiet: assert property (
    sh.role_bit && !sh.three_wire && sh.slave_output_disable && st |-> txd_oe_n)
    else $error("disabled slave drives data");
  a_read_release: assert property (
    sh.three_wire && !sh.dir_write && st |-> txd_oe_n) else $error("read drives data");
  a_cd_level: assert property (
    sh.three_wire && sh.cmd_data_line_present && !sel_n_o && !$past(sel_n_o)
    |-> !cmd_data_oe_n && cmd_data_o == sh.cmd_data_kind) else $error("cmd line wrong");
  a_cd_absent: assert property (
    !(sh.three_wire && sh.cmd_data_line_present) && st |-> cmd_data_oe_n)
    else $error("cmd line driven");
endmodule

bind ssp_core ssp_core_chk u_chk (
  .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sclk_o(sclk_o),
  .sclk_oe_n(sclk_oe_n), .sel_n_o(sel_n_o), .txd_oe_n(txd_oe_n),
  .cmd_data_o(cmd_data_o), .cmd_data_oe_n(cmd_data_oe_n));

// [dv/tb.sv]
// Purpose: self-checking bench of the serial port top
// Assumes: status layout as chosen by the designer
// Notes:   half period of clk_rate 3 leaves room for pin synchronisers
`timescale 1ns/100ps
// ==========================================================
// bench
module tb import ssp_pkg::*; ;
  logic        core_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0;
  logic        sclk_in = 0, sel_n_in = 1, tb_rxd = 0, slv = 0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000, st_v;
  logic [31:0] reg_rdata;
  logic [15:0] reply = 16'h0000, seen;
  logic        sclk_o, sclk_oe_n, sel_n_o, serial_output_line, txd_oe_n;
  logic        cmd_data_o, cmd_data_oe_n, miso;
  wire         rxd_in = slv ? tb_rxd : miso;
  int          err_total = 0, checked = 0;
  always #5 core_clk = ~core_clk;
  ssp_core dut (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sclk_in(sclk_in), .sclk_o(sclk_o), .sclk_oe_n(sclk_oe_n), .sel_n_in(sel_n_in),
    .sel_n_o(sel_n_o), .rxd_in(rxd_in), .serial_output_line(serial_output_line),
    .txd_oe_n(txd_oe_n), .cmd_data_o(cmd_data_o), .cmd_data_oe_n(cmd_data_oe_n));
  ssp_link_slave u_slave (.sclk(sclk_o), .sel_n(sel_n_o), .mosi(serial_output_line),
    .miso(miso), .reply(reply), .seen(seen));
  // ==========================================================
  // bus and check helpers
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    rd(a, v);
    chk(v, e);
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // bounded poll of one status bit
  task automatic wait_st(input int b);
    int i;
    st_v = 32'h0000_0000;
    for (i = 0; i < 600 && st_v[b] !== 1'b1; i++) rd(SSP_OFF_STATUS, st_v);
    if (st_v[b] !== 1'b1) begin
      err_total++;
      complete_run;
    end
  endtask
  // one master frame; zero expected tx means not observed
  task automatic t_frame(input logic [15:0] c1, input logic [10:0] c2, input logic [15:0] tx,
                         input logic [15:0] etx, input logic [15:0] rp, input logic [15:0] erx);
    wr(SSP_OFF_CTRL_SECOND, 32'h0000_0000);
    wr(SSP_OFF_CTRL_FIRST, {16'h0000, c1});
    reply = rp;
    wr(SSP_OFF_DATA, {16'hFFFF, tx});
    wr(SSP_OFF_CTRL_SECOND, {21'h0, c2});
    wait_st(2);
    rchk(SSP_OFF_DATA, {16'h0000, erx});
    if (etx != 16'h0000) chk({16'h0000, seen}, {16'h0000, etx});
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset_role;
    rchk(SSP_OFF_CTRL_SECOND, 32'h0000_0080);
    rchk(SSP_OFF_CTRL_FIRST, 32'h0000_0000);
    rchk(8'h30, 32'h0000_0000);
    rchk(SSP_OFF_DATA, 32'h0000_0000);
    wr(SSP_OFF_CTRL_SECOND, 32'h0000_07BF);
    rchk(SSP_OFF_CTRL_SECOND, 32'h0000_07BF);
    wr(SSP_OFF_CTRL_SECOND, 32'h0000_0002);
    rchk(SSP_OFF_CTRL_SECOND, 32'h0000_0006);
    wr(SSP_OFF_CTRL_SECOND, 32'h0000_0000);
    rchk(SSP_OFF_CTRL_SECOND, 32'h0000_0004);
    wr(SSP_OFF_CTRL_SECOND, 32'h0000_0000);
    rchk(SSP_OFF_CTRL_SECOND, 32'h0000_0000);
  endtask
  task automatic t_slave;
    int i;
    logic [7:0] got;
    wr(SSP_OFF_CTRL_SECOND, 32'h0000_0000);
    wr(SSP_OFF_CTRL_FIRST, 32'h0000_0007);
    wr(SSP_OFF_DATA, 32'h0000_0096);
    wr(SSP_OFF_CTRL_SECOND, 32'h0000_0086);
    slv <= 1'b1;
    sel_n_in <= 1'b0;
    for (i = 7; i >= 0; i--) begin
      tb_rxd <= i[0] ? 1'b1 : 1'b0;
      repeat (8) @(posedge core_clk);
      got[i] = serial_output_line;
      sclk_in <= 1'b1;
      repeat (8) @(posedge core_clk);
      sclk_in <= 1'b0;
    end
    chk({31'h0, txd_oe_n}, 32'h0000_0000);
    repeat (8) @(posedge core_clk);
    sel_n_in <= 1'b1;
    chk({24'h0, got}, 32'h0000_0096);
    wait_st(2);
    rchk(SSP_OFF_DATA, 32'h0000_00AA);
    wr(SSP_OFF_CTRL_SECOND, 32'h0000_0000);
    wr(SSP_OFF_CTRL_SECOND, 32'h0000_008E);
    sel_n_in <= 1'b0;
    repeat (4) @(posedge core_clk);
    chk({31'h0, txd_oe_n}, 32'h0000_0001);
    sel_n_in <= 1'b1;
    wr(SSP_OFF_CTRL_SECOND, 32'h0000_0000);
    wr(SSP_OFF_CTRL_SECOND, 32'h0000_0000);
    slv <= 1'b0;
  endtask
  task automatic t_fill_drain;
    int i;
    for (i = 0; i < 9; i++) wr(SSP_OFF_DATA, 32'h0000_0010 + i);
    rd(SSP_OFF_STATUS, st_v);
    chk({30'h0, st_v[1:0]}, 32'h0000_0000);
    wr(SSP_OFF_CTRL_SECOND, 32'h0000_0083);
    wait_st(3);
    for (i = 0; i < 8; i++) rchk(SSP_OFF_DATA, 32'h0000_0010 + i);
    rchk(SSP_OFF_DATA, 32'h0000_0000);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    t_reset_role;
    t_frame(16'h0307, 11'h082, 16'hF1A5, 16'h00A5, 16'h3500, 16'h0035);
    t_frame(16'h0307, 11'h0B2, 16'h00C4, 16'h0023, 16'h3500, 16'h00AC);
    t_frame(16'h032B, 11'h082, 16'h00A5, 16'h0A50, 16'hABC0, 16'h0ABC);
    t_frame(16'h0301, 11'h082, 16'h000B, 16'h000B, 16'h9000, 16'h0009);
    t_frame(16'h0307, 11'h702, 16'h00A5, 16'h0000, 16'h3500, 16'h0035);
    t_frame(16'h0307, 11'h602, 16'h00A5, 16'h0000, 16'h3500, 16'h0035);
    t_frame(16'h0307, 11'h083, 16'h005A, 16'h0000, 16'h0000, 16'h005A);
    t_slave;
    wr(SSP_OFF_CTRL_FIRST, 32'h0000_0307);
    t_fill_drain;
    complete_run;
  end
endmodule
